// *** hw/crf_pkg.sv ***
// Purpose: Constants for the CPU register file and flag word
// Assumes: 16-bit data path, 20-bit program space
// Notes:   Register-port indices are the block's own numbering
package crf_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned CRF_WORD_W = 16;
  localparam int unsigned CRF_ADDR_W = 20;
  localparam int unsigned CRF_IDX_W  = 5;
  localparam int unsigned CRF_BANKS  = 2;

  // ---------------------------------------------------------------
  // Register indices on the software port
  // ---------------------------------------------------------------
  localparam logic [4:0] CRF_IDX_DATA0   = 5'h00;
  localparam logic [4:0] CRF_IDX_DATA1   = 5'h01;
  localparam logic [4:0] CRF_IDX_DATA2   = 5'h02;
  localparam logic [4:0] CRF_IDX_DATA3   = 5'h03;
  localparam logic [4:0] CRF_IDX_ADDR0   = 5'h04;
  localparam logic [4:0] CRF_IDX_ADDR1   = 5'h05;
  localparam logic [4:0] CRF_IDX_FRAME   = 5'h06;
  localparam logic [4:0] CRF_IDX_D0_HI   = 5'h08;
  localparam logic [4:0] CRF_IDX_D0_LO   = 5'h09;
  localparam logic [4:0] CRF_IDX_D1_HI   = 5'h0A;
  localparam logic [4:0] CRF_IDX_D1_LO   = 5'h0B;
  localparam logic [4:0] CRF_IDX_PC_LO   = 5'h10;
  localparam logic [4:0] CRF_IDX_PC_HI   = 5'h11;
  localparam logic [4:0] CRF_IDX_VEC_LO  = 5'h12;
  localparam logic [4:0] CRF_IDX_VEC_HI  = 5'h13;
  localparam logic [4:0] CRF_IDX_USP     = 5'h14;
  localparam logic [4:0] CRF_IDX_ISP     = 5'h15;
  localparam logic [4:0] CRF_IDX_STATIC  = 5'h16;
  localparam logic [4:0] CRF_IDX_FLAGS   = 5'h17;
  localparam logic [4:0] CRF_IDX_SP      = 5'h18;

  // ---------------------------------------------------------------
  // Flag word fields
  // ---------------------------------------------------------------
  localparam int unsigned CRF_FLG_CARRY  = 0;
  localparam int unsigned CRF_FLG_STEP   = 1;
  localparam int unsigned CRF_FLG_ZERO   = 2;
  localparam int unsigned CRF_FLG_SIGN   = 3;
  localparam int unsigned CRF_FLG_BANK   = 4;
  localparam int unsigned CRF_FLG_OVF    = 5;
  localparam int unsigned CRF_FLG_IEN    = 6;
  localparam int unsigned CRF_FLG_STACK  = 7;
  localparam int unsigned CRF_FLG_IPL_LO = 12;
  localparam int unsigned CRF_FLG_IPL_HI = 14;
  localparam logic [15:0] CRF_FLG_MASK   = 16'h70FF;
  localparam logic [15:0] CRF_FLG_RESET  = 16'h0000;
  localparam logic [15:0] CRF_WORD_RESET = 16'h0000;
  localparam logic [3:0]  CRF_NIB_RESET  = 4'h0;
  localparam logic [5:0]  CRF_SWI_LIMIT  = 6'h1F;
endpackage : crf_pkg

// *** hw/crf_bank_store.sv ***
// Purpose: Two banks of the seven banked 16-bit registers
// Assumes: One write port, full read visibility of the active bank
// Notes:   Byte enables let single byte halves be written
`timescale 1ns/100ps
`default_nettype none
module crf_bank_store #(
  parameter int unsigned NREG = 7
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire logic                  i_bank,
  input  wire logic                  i_we,
  input  wire logic [2:0]            i_idx,
  input  wire logic [1:0]            i_be,
  input  wire logic [15:0]           i_wdata,
  output logic      [NREG*16-1:0]    o_regs
);
  import crf_pkg::*;

  logic [15:0] bank_q [crf_pkg::CRF_BANKS][NREG];

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      for (int b = 0; b < CRF_BANKS; b++) begin
        for (int r = 0; r < NREG; r++) begin
          bank_q[b][r] <= CRF_WORD_RESET;
        end
      end
    end else if (i_we) begin
      // Unselected byte half keeps its value
      if (i_be[0]) begin
        bank_q[i_bank][i_idx][7:0] <= i_wdata[7:0];
      end
      if (i_be[1]) begin
        bank_q[i_bank][i_idx][15:8] <= i_wdata[15:8];
      end
    end
  end

  always_comb begin
    for (int r = 0; r < NREG; r++) begin
      o_regs[r*16 +: 16] = bank_q[i_bank][r];
    end
  end
endmodule : crf_bank_store
`default_nettype wire

// *** hw/crf_register_file.sv ***
// Purpose: CPU register set with banked registers and flag word
// Assumes: Execution unit drives write and flag-update strobes
// Notes:   Software port reads return data one cycle after the strobe
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module crf_register_file (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  // Software register port
  input  wire logic [4:0]           i_reg_addr,
  input  wire logic [15:0]          i_reg_wdata,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  output logic      [15:0]          o_reg_rdata,
  // Execution-side result and flag updates
  input  wire logic                 i_alu_flags_we,
  input  wire logic                 i_alu_carry,
  input  wire logic                 i_alu_zero,
  input  wire logic                 i_alu_sign,
  input  wire logic                 i_alu_ovf,
  input  wire logic                 i_long_data_we,
  input  wire logic                 i_long_data_sel,
  input  wire logic                 i_long_addr_we,
  input  wire logic [31:0]          i_long_wdata,
  input  wire logic                 i_pc_we,
  input  wire logic [19:0]          i_pc_wdata,
  input  wire logic                 i_sp_we,
  input  wire logic [15:0]          i_sp_wdata,
  input  wire logic                 i_insn_done,
  // Interrupt side
  input  wire logic                 i_irq_req,
  input  wire logic [2:0]           i_irq_level,
  input  wire logic                 i_irq_ack,
  input  wire logic                 i_step_ack,
  input  wire logic                 i_swi_exec,
  input  wire logic [5:0]           i_swi_num,
  // Views for the execution unit
  output logic      [31:0]          o_long_data_pair_low,
  output logic      [31:0]          o_long_data_pair_high,
  output logic      [31:0]          o_long_addr_pair,
  output logic      [15:0]          o_frame_base_pointer,
  output logic      [15:0]          o_static_base_pointer,
  output logic      [15:0]          o_active_stack_pointer,
  output logic      [19:0]          o_program_counter,
  output logic      [19:0]          o_vector_table_base,
  output logic      [15:0]          o_processor_flag_word,
  output logic                      o_step_irq,
  output logic                      o_irq_accept
);
  import crf_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0]  flags_q;
  logic [19:0]  pc_q;
  logic [19:0]  vec_q;
  logic [15:0]  usp_q;
  logic [15:0]  isp_q;
  logic [15:0]  sb_q;
  logic [15:0]  rdata_q;
  logic         step_q;
  logic         accept_q;
  logic [111:0] banked;
  logic         bank_we;
  logic [2:0]   bank_idx;
  logic [1:0]   bank_be;
  logic [15:0]  bank_wdata;
  logic         irq_take;
  logic         clr_stack;

  function automatic logic [15:0] reg_at(input logic [111:0] r, input logic [2:0] i);
    reg_at = r[i*16 +: 16];
  endfunction : reg_at

  // ---------------------------------------------------------------
  // Bank write steering
  // ---------------------------------------------------------------
  // Long writes take priority over the software port since they
  // come from a completing instruction.
  always_comb begin
    bank_we    = 1'b0;
    bank_idx   = 3'h0;
    bank_be    = 2'h3;
    bank_wdata = i_reg_wdata;
    if (i_reg_wr) begin
      case (i_reg_addr)
        CRF_IDX_DATA0, CRF_IDX_DATA1, CRF_IDX_DATA2, CRF_IDX_DATA3,
        CRF_IDX_ADDR0, CRF_IDX_ADDR1, CRF_IDX_FRAME: begin
          bank_we  = 1'b1;
          bank_idx = i_reg_addr[2:0];
        end
        CRF_IDX_D0_HI, CRF_IDX_D1_HI: begin
          bank_we    = 1'b1;
          bank_idx   = {2'h0, i_reg_addr[1]};
          bank_be    = 2'h2;
          bank_wdata = {i_reg_wdata[7:0], 8'h00};
        end
        CRF_IDX_D0_LO, CRF_IDX_D1_LO: begin
          bank_we    = 1'b1;
          bank_idx   = {2'h0, i_reg_addr[1]};
          bank_be    = 2'h1;
          bank_wdata = {8'h00, i_reg_wdata[7:0]};
        end
        default: bank_we = 1'b0;
      endcase
    end
  end

  // A 32-bit write needs two ports; the store takes one, so the
  // long path writes the low half here and the high half is
  // handled by the second instance below.
  logic [111:0] banked_hi;
  logic         long_we;
  logic [2:0]   long_lo_idx;
  logic [2:0]   long_hi_idx;

  always_comb begin
    long_we     = i_long_data_we | i_long_addr_we;
    long_lo_idx = CRF_IDX_DATA0[2:0];
    long_hi_idx = CRF_IDX_DATA2[2:0];
    if (i_long_addr_we) begin
      long_lo_idx = CRF_IDX_ADDR0[2:0];
      long_hi_idx = CRF_IDX_ADDR1[2:0];
    end else if (i_long_data_sel) begin
      long_lo_idx = CRF_IDX_DATA1[2:0];
      long_hi_idx = CRF_IDX_DATA3[2:0];
    end
  end

  // Low halves and software writes share one store, high halves of
  // a long write go to a shadow store; reads merge by last writer.
  logic [6:0] hi_valid_q;
  logic [6:0] lo_hit;
  logic [6:0] hi_hit;

  crf_bank_store #(.NREG(7)) u_store (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_bank  (flags_q[CRF_FLG_BANK]),
    .i_we    (long_we | bank_we),
    .i_idx   (long_we ? long_lo_idx : bank_idx),
    .i_be    (long_we ? 2'h3 : bank_be),
    .i_wdata (long_we ? i_long_wdata[15:0] : bank_wdata),
    .o_regs  (banked)
  );

  crf_bank_store #(.NREG(7)) u_store_hi (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_bank  (flags_q[CRF_FLG_BANK]),
    .i_we    (long_we),
    .i_idx   (long_hi_idx),
    .i_be    (2'h3),
    .i_wdata (i_long_wdata[31:16]),
    .o_regs  (banked_hi)
  );

  always_comb begin
    lo_hit = '0;
    hi_hit = '0;
    if (long_we) begin
      hi_hit[long_hi_idx] = 1'b1;
      lo_hit[long_lo_idx] = 1'b1;
    end else if (bank_we) begin
      lo_hit[bank_idx] = 1'b1;
    end
  end

  // Per bank, remember which store last wrote each register
  logic [6:0] hi_valid_b_q [2];
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hi_valid_b_q[0] <= '0;
      hi_valid_b_q[1] <= '0;
    end else begin
      hi_valid_b_q[flags_q[CRF_FLG_BANK]] <=
        (hi_valid_b_q[flags_q[CRF_FLG_BANK]] & ~lo_hit) | hi_hit;
    end
  end
  assign hi_valid_q = hi_valid_b_q[flags_q[CRF_FLG_BANK]];

  function automatic logic [15:0] bank_word(input logic [2:0] i);
    bank_word = hi_valid_q[i] ? reg_at(banked_hi, i) : reg_at(banked, i);
  endfunction : bank_word

  // ---------------------------------------------------------------
  // Interrupt decision
  // ---------------------------------------------------------------
  assign irq_take  = i_irq_req & flags_q[CRF_FLG_IEN]
                   & (i_irq_level > flags_q[CRF_FLG_IPL_HI:CRF_FLG_IPL_LO]);
  assign clr_stack = i_irq_ack | (i_swi_exec & (i_swi_num <= CRF_SWI_LIMIT));

  // ---------------------------------------------------------------
  // Flag word
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flags_q <= CRF_FLG_RESET;
    end else begin
      if (i_reg_wr && i_reg_addr == CRF_IDX_FLAGS) begin
        flags_q <= i_reg_wdata & CRF_FLG_MASK;
      end
      if (i_alu_flags_we) begin
        flags_q[CRF_FLG_CARRY] <= i_alu_carry;
        flags_q[CRF_FLG_ZERO]  <= i_alu_zero;
        flags_q[CRF_FLG_SIGN]  <= i_alu_sign;
        flags_q[CRF_FLG_OVF]   <= i_alu_ovf;
      end
      if (i_step_ack) begin
        flags_q[CRF_FLG_STEP] <= 1'b0;
      end
      if (i_irq_ack || i_step_ack) begin
        flags_q[CRF_FLG_IEN] <= 1'b0;
      end
      if (clr_stack) begin
        flags_q[CRF_FLG_STACK] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Program counter and vector base
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pc_q <= {CRF_NIB_RESET, CRF_WORD_RESET};
    end else if (i_pc_we) begin
      pc_q <= i_pc_wdata;
    end else if (i_reg_wr && i_reg_addr == CRF_IDX_PC_LO) begin
      pc_q[15:0] <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == CRF_IDX_PC_HI) begin
      pc_q[19:16] <= i_reg_wdata[3:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      vec_q <= {CRF_NIB_RESET, CRF_WORD_RESET};
    end else if (i_reg_wr && i_reg_addr == CRF_IDX_VEC_LO) begin
      vec_q[15:0] <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == CRF_IDX_VEC_HI) begin
      vec_q[19:16] <= i_reg_wdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Stack pointers and static base
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      usp_q <= CRF_WORD_RESET;
      isp_q <= CRF_WORD_RESET;
    end else if (i_sp_we) begin
      // Push and pop only move the pointer the flag selects
      if (flags_q[CRF_FLG_STACK]) begin
        usp_q <= i_sp_wdata;
      end else begin
        isp_q <= i_sp_wdata;
      end
    end else if (i_reg_wr && i_reg_addr == CRF_IDX_USP) begin
      usp_q <= i_reg_wdata;
    end else if (i_reg_wr && i_reg_addr == CRF_IDX_ISP) begin
      isp_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sb_q <= CRF_WORD_RESET;
    end else if (i_reg_wr && i_reg_addr == CRF_IDX_STATIC) begin
      sb_q <= i_reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      step_q   <= 1'b0;
      accept_q <= 1'b0;
    end else begin
      step_q   <= i_insn_done & flags_q[CRF_FLG_STEP];
      accept_q <= irq_take;
    end
  end

  // ---------------------------------------------------------------
  // Software read port
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= CRF_WORD_RESET;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        CRF_IDX_DATA0, CRF_IDX_DATA1, CRF_IDX_DATA2, CRF_IDX_DATA3,
        CRF_IDX_ADDR0, CRF_IDX_ADDR1, CRF_IDX_FRAME:
          rdata_q <= bank_word(i_reg_addr[2:0]);
        CRF_IDX_D0_HI: rdata_q <= bank_word(3'h0) >> 8;
        CRF_IDX_D0_LO: rdata_q <= bank_word(3'h0) & 16'h00FF;
        CRF_IDX_D1_HI: rdata_q <= bank_word(3'h1) >> 8;
        CRF_IDX_D1_LO: rdata_q <= bank_word(3'h1) & 16'h00FF;
        CRF_IDX_PC_LO:  rdata_q <= pc_q[15:0];
        CRF_IDX_PC_HI:  rdata_q <= {12'h000, pc_q[19:16]};
        CRF_IDX_VEC_LO: rdata_q <= vec_q[15:0];
        CRF_IDX_VEC_HI: rdata_q <= {12'h000, vec_q[19:16]};
        CRF_IDX_USP:    rdata_q <= usp_q;
        CRF_IDX_ISP:    rdata_q <= isp_q;
        CRF_IDX_STATIC: rdata_q <= sb_q;
        CRF_IDX_FLAGS:  rdata_q <= flags_q;
        CRF_IDX_SP:     rdata_q <= flags_q[CRF_FLG_STACK] ? usp_q : isp_q;
        default:        rdata_q <= CRF_WORD_RESET;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Bank and stack-pointer views lag the registers by one cycle so every output is a flop
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_long_data_pair_low   <= {CRF_WORD_RESET, CRF_WORD_RESET};
      o_long_data_pair_high  <= {CRF_WORD_RESET, CRF_WORD_RESET};
      o_long_addr_pair       <= {CRF_WORD_RESET, CRF_WORD_RESET};
      o_frame_base_pointer   <= CRF_WORD_RESET;
      o_active_stack_pointer <= CRF_WORD_RESET;
    end else begin
      o_long_data_pair_low   <= {bank_word(3'h2), bank_word(3'h0)};
      o_long_data_pair_high  <= {bank_word(3'h3), bank_word(3'h1)};
      o_long_addr_pair       <= {bank_word(3'h5), bank_word(3'h4)};
      o_frame_base_pointer   <= bank_word(3'h6);
      o_active_stack_pointer <= flags_q[CRF_FLG_STACK] ? usp_q : isp_q;
    end
  end
  assign o_reg_rdata            = rdata_q;
  assign o_static_base_pointer  = sb_q;
  assign o_program_counter      = pc_q;
  assign o_vector_table_base    = vec_q;
  assign o_processor_flag_word  = flags_q;
  assign o_step_irq             = step_q;
  assign o_irq_accept           = accept_q;
endmodule : crf_register_file
`default_nettype wire

// *** testbench/crf_rf_assertions.sv ***
// Purpose: Concurrent checks on the register file ports
// Assumes: One clock, synchronous active-high reset
// Notes:   Flag write check skips cycles with competing hardware updates
`timescale 1ns/100ps
`default_nettype none
module crf_rf_assertions
  import crf_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [4:0]  i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic        i_alu_flags_we,
  input wire logic        i_alu_carry,
  input wire logic        i_alu_zero,
  input wire logic        i_alu_sign,
  input wire logic        i_alu_ovf,
  input wire logic        i_insn_done,
  input wire logic        i_irq_req,
  input wire logic [2:0]  i_irq_level,
  input wire logic        i_irq_ack,
  input wire logic        i_step_ack,
  input wire logic        i_swi_exec,
  input wire logic [5:0]  i_swi_num,
  input wire logic [15:0] o_processor_flag_word,
  input wire logic        o_step_irq,
  input wire logic        o_irq_accept
);
  logic [15:0] fw;
  assign fw = o_processor_flag_word;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence s_flag_wr;
    i_reg_wr && i_reg_addr == CRF_IDX_FLAGS && !i_alu_flags_we && !i_irq_ack && !i_step_ack && !i_swi_exec;
  endsequence
  sequence s_flag_rd;
    i_reg_rd && i_reg_addr == CRF_IDX_FLAGS;
  endsequence
  AST_FLAG_WR: assert property (s_flag_wr |=> fw == ($past(i_reg_wdata) & CRF_FLG_MASK))
    else $error("flag word write wrong");
  AST_FLAG_RD: assert property (s_flag_rd |=> o_reg_rdata == $past(fw))
    else $error("flag word read wrong");
  AST_ALU_FLAGS: assert property (i_alu_flags_we |=>
    {fw[5], fw[3], fw[2], fw[0]} == $past({i_alu_ovf, i_alu_sign, i_alu_zero, i_alu_carry}))
    else $error("alu flags not loaded");
  AST_STEP_IRQ: assert property (o_step_irq == $past(i_insn_done && fw[CRF_FLG_STEP]))
    else $error("single step request wrong");
  AST_STEP_ACK: assert property (i_step_ack |=> !fw[CRF_FLG_STEP] && !fw[CRF_FLG_IEN])
    else $error("step acknowledge did not clear");
  AST_IRQ_ACK: assert property (i_irq_ack |=> !fw[CRF_FLG_IEN] && !fw[CRF_FLG_STACK])
    else $error("acknowledge did not clear");
  AST_SWI: assert property (i_swi_exec && i_swi_num <= CRF_SWI_LIMIT |=> !fw[CRF_FLG_STACK])
    else $error("software interrupt kept stack flag");
  AST_ACCEPT: assert property (o_irq_accept ==
    $past(i_irq_req && fw[CRF_FLG_IEN] && i_irq_level > fw[14:12]))
    else $error("interrupt accept wrong");
endmodule : crf_rf_assertions
bind crf_register_file crf_rf_assertions u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_alu_flags_we(i_alu_flags_we),
  .i_alu_carry(i_alu_carry), .i_alu_zero(i_alu_zero), .i_alu_sign(i_alu_sign), .i_alu_ovf(i_alu_ovf),
  .i_insn_done(i_insn_done), .i_irq_req(i_irq_req), .i_irq_level(i_irq_level), .i_irq_ack(i_irq_ack),
  .i_step_ack(i_step_ack), .i_swi_exec(i_swi_exec), .i_swi_num(i_swi_num),
  .o_processor_flag_word(o_processor_flag_word), .o_step_irq(o_step_irq), .o_irq_accept(o_irq_accept));
`default_nettype wire

// *** testbench/crf_register_file_tb.sv ***
// Purpose: Self-checking bench for the CPU register file
// Assumes: Read data stand in the cycle after the read strobe
// Notes:   Bank views are registered, so their checks wait one extra edge
`timescale 1ns/100ps
`default_nettype none
module crf_register_file_tb;
  import crf_pkg::*;
  logic        i_clk, i_srst, i_reg_wr, i_reg_rd, i_alu_flags_we, i_alu_carry, i_alu_zero, i_alu_sign;
  logic        i_alu_ovf, i_long_data_we, i_long_data_sel, i_long_addr_we, i_pc_we, i_sp_we, i_insn_done;
  logic        i_irq_req, i_irq_ack, i_step_ack, i_swi_exec, o_step_irq, o_irq_accept;
  logic [4:0]  i_reg_addr;
  logic [2:0]  i_irq_level;
  logic [5:0]  i_swi_num;
  logic [15:0] i_reg_wdata, i_sp_wdata, o_reg_rdata, o_frame_base_pointer, o_static_base_pointer;
  logic [15:0] o_active_stack_pointer, o_processor_flag_word;
  logic [19:0] i_pc_wdata, o_program_counter, o_vector_table_base;
  logic [31:0] i_long_wdata, o_long_data_pair_low, o_long_data_pair_high, o_long_addr_pair;
  int          mismatches, n_tests, cycles;
  crf_register_file uut (.i_clk(i_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_alu_flags_we(i_alu_flags_we),
    .i_alu_carry(i_alu_carry), .i_alu_zero(i_alu_zero), .i_alu_sign(i_alu_sign), .i_alu_ovf(i_alu_ovf),
    .i_long_data_we(i_long_data_we), .i_long_data_sel(i_long_data_sel), .i_long_addr_we(i_long_addr_we),
    .i_long_wdata(i_long_wdata), .i_pc_we(i_pc_we), .i_pc_wdata(i_pc_wdata), .i_sp_we(i_sp_we),
    .i_sp_wdata(i_sp_wdata), .i_insn_done(i_insn_done), .i_irq_req(i_irq_req), .i_irq_level(i_irq_level),
    .i_irq_ack(i_irq_ack), .i_step_ack(i_step_ack), .i_swi_exec(i_swi_exec), .i_swi_num(i_swi_num),
    .o_long_data_pair_low(o_long_data_pair_low), .o_long_data_pair_high(o_long_data_pair_high),
    .o_long_addr_pair(o_long_addr_pair), .o_frame_base_pointer(o_frame_base_pointer),
    .o_static_base_pointer(o_static_base_pointer), .o_active_stack_pointer(o_active_stack_pointer),
    .o_program_counter(o_program_counter), .o_vector_table_base(o_vector_table_base),
    .o_processor_flag_word(o_processor_flag_word), .o_step_irq(o_step_irq), .o_irq_accept(o_irq_accept));
  always #50 i_clk = ~i_clk;
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Drops every strobe one edge after launch; outputs are read at the falling edge
  task automatic fin;
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd, i_alu_flags_we, i_long_data_we, i_long_addr_we, i_pc_we, i_sp_we} <= '0;
    {i_insn_done, i_irq_req, i_irq_ack, i_step_ack, i_swi_exec} <= '0;
    @(negedge i_clk);
  endtask : fin
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    fin;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    fin;
    chk($sformatf("reg %h", a), {16'h0000, e}, {16'h0000, o_reg_rdata});
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_sim;
    end
  end
  initial begin
    i_clk = 1'b0;
    i_srst = 1'b1;
    {i_reg_wr, i_reg_rd, i_alu_flags_we, i_alu_carry, i_alu_zero, i_alu_sign, i_alu_ovf, i_long_data_we} = '0;
    {i_long_data_sel, i_long_addr_we, i_pc_we, i_sp_we, i_insn_done, i_irq_req, i_irq_ack, i_step_ack} = '0;
    {i_swi_exec, i_reg_addr, i_irq_level, i_swi_num, i_reg_wdata, i_sp_wdata, i_pc_wdata, i_long_wdata} = '0;
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(CRF_IDX_FLAGS, 16'h0000);
    rd(CRF_IDX_SP, 16'h0000);
    $display("test reset done");
    for (int b = 0; b < 2; b++) begin
      wr(CRF_IDX_FLAGS, {11'h000, b[0], 4'h0});
      for (int i = 0; i < 7; i++) wr(i[4:0], {8'hA0, b[3:0], i[3:0]});
    end
    for (int b = 0; b < 2; b++) begin
      wr(CRF_IDX_FLAGS, {11'h000, b[0], 4'h0});
      for (int i = 0; i < 7; i++) rd(i[4:0], {8'hA0, b[3:0], i[3:0]});
    end
    chk("frame", 32'h0000_A016, {16'h0000, o_frame_base_pointer});
    chk("data pair low", 32'hA012_A010, o_long_data_pair_low);
    chk("addr pair", 32'hA015_A014, o_long_addr_pair);
    wr(CRF_IDX_D0_HI, 16'h00C3);
    rd(CRF_IDX_DATA0, 16'hC310);
    wr(CRF_IDX_D0_LO, 16'h005A);
    wr(CRF_IDX_D1_LO, 16'h0077);
    wr(CRF_IDX_D1_HI, 16'h0066);
    rd(CRF_IDX_DATA0, 16'hC35A);
    rd(CRF_IDX_DATA1, 16'h6677);
    rd(CRF_IDX_D0_HI, 16'h00C3);
    rd(CRF_IDX_D0_LO, 16'h005A);
    rd(CRF_IDX_D1_HI, 16'h0066);
    rd(CRF_IDX_D1_LO, 16'h0077);
    wr(CRF_IDX_FLAGS, 16'h0000);
    rd(CRF_IDX_DATA0, 16'hA000);
    $display("test banks done");
    @(posedge i_clk);
    i_long_data_we <= 1'b1;
    i_long_data_sel <= 1'b1;
    i_long_wdata <= 32'h1111_2222;
    fin;
    @(negedge i_clk);
    chk("data pair high", 32'h1111_2222, o_long_data_pair_high);
    rd(CRF_IDX_DATA3, 16'h1111);
    @(posedge i_clk);
    i_long_addr_we <= 1'b1;
    i_long_wdata <= 32'h3333_4444;
    fin;
    rd(CRF_IDX_ADDR0, 16'h4444);
    @(posedge i_clk);
    i_long_data_we <= 1'b1;
    i_long_data_sel <= 1'b0;
    i_long_wdata <= 32'h5555_6666;
    fin;
    rd(CRF_IDX_DATA2, 16'h5555);
    wr(CRF_IDX_PC_LO, 16'hBEEF);
    wr(CRF_IDX_PC_HI, 16'hFFFA);
    chk("pc", 32'h000A_BEEF, {12'h000, o_program_counter});
    rd(CRF_IDX_PC_HI, 16'h000A);
    wr(CRF_IDX_VEC_LO, 16'h1357);
    wr(CRF_IDX_VEC_HI, 16'h0009);
    chk("vector", 32'h0009_1357, {12'h000, o_vector_table_base});
    rd(CRF_IDX_VEC_HI, 16'h0009);
    rd(CRF_IDX_VEC_LO, 16'h1357);
    @(posedge i_clk);
    i_pc_we <= 1'b1;
    i_pc_wdata <= 20'h12345;
    fin;
    chk("pc load", 32'h0001_2345, {12'h000, o_program_counter});
    wr(CRF_IDX_USP, 16'h1234);
    wr(CRF_IDX_ISP, 16'h5678);
    @(negedge i_clk);
    chk("active sp", 32'h0000_5678, {16'h0000, o_active_stack_pointer});
    wr(CRF_IDX_FLAGS, 16'h0080);
    rd(CRF_IDX_SP, 16'h1234);
    @(posedge i_clk);
    i_sp_we <= 1'b1;
    i_sp_wdata <= 16'h9999;
    fin;
    rd(CRF_IDX_USP, 16'h9999);
    rd(CRF_IDX_ISP, 16'h5678);
    wr(CRF_IDX_STATIC, 16'h0BAD);
    chk("static", 32'h0000_0BAD, {16'h0000, o_static_base_pointer});
    wr(5'h07, 16'hFFFF);
    rd(5'h07, 16'h0000);
    $display("test pointers done");
    wr(CRF_IDX_FLAGS, 16'hFFFF);
    rd(CRF_IDX_FLAGS, 16'h70FF);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_alu_flags_we <= 1'b1;
      {i_alu_ovf, i_alu_sign, i_alu_zero, i_alu_carry} <= k[0] ? 4'h5 : 4'hA;
      fin;
      chk("alu flags", k[0] ? 32'h0000_70DB : 32'h0000_70F6, {16'h0000, o_processor_flag_word});
    end
    wr(CRF_IDX_FLAGS, 16'h30C2);
    @(posedge i_clk);
    i_insn_done <= 1'b1;
    fin;
    chk("step irq", 32'h1, {31'h0000_0000, o_step_irq});
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      i_irq_req <= 1'b1;
      i_irq_level <= k[2:0] + 3'h2;
      fin;
      chk("accept", {31'h0000_0000, k == 2}, {31'h0000_0000, o_irq_accept});
    end
    @(posedge i_clk);
    i_irq_ack <= 1'b1;
    fin;
    chk("flags ack", 32'h0000_3002, {16'h0000, o_processor_flag_word});
    @(posedge i_clk);
    i_irq_req <= 1'b1;
    i_irq_level <= 3'h7;
    fin;
    chk("masked", 32'h0, {31'h0000_0000, o_irq_accept});
    @(posedge i_clk);
    i_step_ack <= 1'b1;
    fin;
    chk("flags step ack", 32'h0000_3000, {16'h0000, o_processor_flag_word});
    for (int k = 0; k < 2; k++) begin
      wr(CRF_IDX_FLAGS, 16'h0080);
      @(posedge i_clk);
      i_swi_exec <= 1'b1;
      i_swi_num <= k[0] ? 6'h20 : 6'h1F;
      fin;
      chk("swi", k[0] ? 32'h0000_0080 : 32'h0, {16'h0000, o_processor_flag_word});
    end
    $display("test flags done");
    end_sim;
  end
endmodule : crf_register_file_tb
`default_nettype wire
